// ===== verilog/temp_adc_pkg.sv
//------------------------------------------------------------------
// constants shared by the temperature converter control block
//------------------------------------------------------------------
package temp_adc_pkg;

    //------------------------------------------------------------------
    // apb geometry and register map
    //------------------------------------------------------------------
    localparam int unsigned APB_AW     = 8;
    localparam int unsigned APB_DW     = 32;
    localparam int unsigned REG_W      = 16;
    localparam int unsigned IDX_RESULT = 0;
    localparam int unsigned IDX_STATUS = 1;
    localparam int unsigned IDX_CONFIG = 6;
    localparam logic [APB_AW-1:0] ADDR_RESULT = APB_AW'(IDX_RESULT * 4);
    localparam logic [APB_AW-1:0] ADDR_STATUS = APB_AW'(IDX_STATUS * 4);
    localparam logic [APB_AW-1:0] ADDR_CONFIG = APB_AW'(IDX_CONFIG * 4);

    //------------------------------------------------------------------
    // configuration field positions
    //------------------------------------------------------------------
    localparam int unsigned CFG_RES_LO     = 0;
    localparam int unsigned CFG_RES_HI     = 1;
    localparam int unsigned CFG_GAIN_LO    = 2;
    localparam int unsigned CFG_GAIN_HI    = 3;
    localparam int unsigned CFG_MUX_LO     = 4;
    localparam int unsigned CFG_MUX_HI     = 5;
    localparam int unsigned CFG_REFSEL_LO  = 6;
    localparam int unsigned CFG_REFSEL_HI  = 7;
    localparam int unsigned CFG_INT_REF    = 8;
    localparam int unsigned CFG_INT_SENSE  = 9;
    localparam int unsigned CFG_CONV_ON    = 10;
    localparam int unsigned CFG_EXC_ON     = 11;
    localparam int unsigned CFG_FACTORY_LO = 14;
    localparam int unsigned CFG_FACTORY_HI = 15;

    // status bit positions
    localparam int unsigned STAT_BUSY  = 0;
    localparam int unsigned STAT_FRESH = 1;

    // reset values
    localparam logic [REG_W-1:0] CONFIG_RESET = 16'h0000;
    localparam logic [REG_W-1:0] RESULT_RESET = 16'h0000;

    //------------------------------------------------------------------
    // timing: clock rate and conversion times in milliseconds
    //------------------------------------------------------------------
    localparam int unsigned CLK_MHZ            = 250;
    localparam int unsigned KHZ_PER_MHZ        = 1000;
    localparam int unsigned CYCLES_PER_MS_DFLT = CLK_MHZ * KHZ_PER_MHZ;
    localparam int unsigned TIMER_W            = 32;
    localparam int unsigned INT_TIME_MS      [4] = '{3, 6, 12, 24};
    localparam int unsigned EXT_TIME_MS_XREF [4] = '{6, 24, 50, 100};
    localparam int unsigned EXT_TIME_MS_IREF [4] = '{8, 32, 64, 128};

    //------------------------------------------------------------------
    // resolution: magnitude bits per code, sign bit not counted
    //------------------------------------------------------------------
    localparam int unsigned RAW_MAG_BITS     = 15;
    localparam int unsigned INT_FULL_BITS    = 12;
    localparam int unsigned INT_RES_BITS [4] = '{9, 10, 11, 12};
    localparam int unsigned EXT_RES_BITS [4] = '{11, 13, 14, 15};
    localparam int unsigned GAIN_FACTOR_W    = 4;

    // converter reference source seen by the analog side
    typedef enum logic [2:0] {
        REF_PIN      = 3'b000,
        REF_EXC      = 3'b001,
        REF_SUPPLY   = 3'b010,
        REF_RESERVED = 3'b011,
        REF_INTERNAL = 3'b100
    } ref_src_t;

    // conversion sequencer
    typedef enum logic [1:0] {
        CONV_OFF  = 2'b00,
        CONV_RUN  = 2'b01,
        CONV_DONE = 2'b10
    } conv_state_t;

endpackage : temp_adc_pkg

// ===== verilog/conv_timer.sv
`timescale 1ns/1ps
`default_nettype none

//------------------------------------------------------------------
// down counter that times one conversion
//------------------------------------------------------------------
module conv_timer #(
    parameter int unsigned W = 32
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    input  wire logic         run,
    // status
    output logic              done,
    output logic [W-1:0]      remaining
);

    logic [W-1:0] count_reg;

    // last counted cycle of the interval
    assign done      = run && (count_reg == W'(1));
    assign remaining = count_reg;

    // load wins over counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= load_value;
        end else if (run && (count_reg != '0)) begin
            count_reg <= count_reg - W'(1);
        end
    end

endmodule : conv_timer

`default_nettype wire

// ===== verilog/result_formatter.sv
`timescale 1ns/1ps
`default_nettype none

//------------------------------------------------------------------
// sign-extended result word from the raw sample, right-justified in external mode and at internal code 3
//------------------------------------------------------------------
module result_formatter
    import temp_adc_pkg::*;
(
    // raw converter sample, full scale signed
    input  wire logic [REG_W-1:0] raw_sample,
    // mode
    input  wire logic             internal_mode,
    input  wire logic [1:0]       res_code,
    // formatted word
    output logic      [REG_W-1:0] result_word
);

    logic signed [REG_W-1:0] raw_s;
    logic signed [REG_W-1:0] int_full;
    logic signed [REG_W-1:0] int_trunc;
    logic signed [REG_W-1:0] ext_word;
    logic        [3:0]       int_drop;
    logic        [3:0]       ext_shift;

    // shift amounts per resolution code
    assign int_drop  = 4'(INT_FULL_BITS - INT_RES_BITS[res_code]);
    assign ext_shift = 4'(RAW_MAG_BITS - EXT_RES_BITS[res_code]);

    // internal: counts of the finest step, coarse codes clear low bits
    assign raw_s     = raw_sample;
    assign int_full  = raw_s >>> (RAW_MAG_BITS - INT_FULL_BITS);
    assign int_trunc = (int_full >>> int_drop) <<< int_drop;

    // external: arithmetic shift copies the sign into the upper bits
    assign ext_word    = raw_s >>> ext_shift;
    assign result_word = internal_mode ? int_trunc : ext_word;

endmodule : result_formatter

`default_nettype wire

// ===== verilog/temp_adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - internal sensing resolution is 9 to 12 bits plus sign per code.
// - internal sensing conversion lasts 3, 6, 12 or 24 ms per code.
// - internal result counts 0.0625 degree steps in two's complement.
// - result right-justified in 16 bits, sign copied into unused upper bits; internal codes 0 to 2 here clear low bits instead of shifting.
// - external mode measures the chosen input pair set by configuration.
// - amplifier gain 1, 2, 4 or 8 from gain field bits 3 and 2.
// - excitation current source connected while config bit 11 is set.
// - bit 8 picks internal reference, else pair picks pin, exc, supply.
// - external resolution is 11, 13, 14 or 15 bits plus sign.
// - external with outside reference lasts 6, 24, 50 or 100 ms.
// - external with internal reference lasts 8, 32, 64 or 128 ms.
// - bit 9 selects internal sensing, bit 10 enables the converter.

module temp_adc_ctrl
    import temp_adc_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DFLT
) (
    // clock and reset
    input  wire logic [0:0]         pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic [APB_AW-1:0]  paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [APB_DW-1:0]  pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [APB_DW-1:0]  prdata,
    output logic                    pready,
    output logic                    pslverr,
    // raw sample from the converter core, same clock
    input  wire logic [REG_W-1:0]   adc_raw_sample,
    // analog front-end controls
    output logic                    converter_on,
    output logic                    internal_sensing_select,
    output logic [1:0]              resolution_select,
    output logic [1:0]              amp_gain_select,
    output logic [GAIN_FACTOR_W-1:0] amp_gain_factor,
    output ref_src_t                converter_reference,
    output logic [1:0]              input_mux_select,
    output logic                    excitation_current_on,
    // conversion events
    output logic                    conversion_busy,
    output logic                    conversion_strobe
);

    //------------------------------------------------------------------
    // declarations
    //------------------------------------------------------------------
    logic [REG_W-1:0]   config_reg;
    logic [REG_W-1:0]   config_next;
    logic [REG_W-1:0]   result_reg;
    logic               fresh_reg;
    logic               fresh_next;
    logic [APB_DW-1:0]  prdata_reg;
    logic [APB_DW-1:0]  prdata_next;
    logic               pslverr_reg;
    logic               pslverr_next;
    conv_state_t        state_reg;
    conv_state_t        state_next;

    logic               setup_phase;
    logic               access_done;
    logic               hit_result;
    logic               hit_status;
    logic               hit_config;
    logic               hit_any;
    logic               cfg_write;
    logic               result_read;

    logic               cfg_conv_on;
    logic               cfg_int_sense;
    logic               cfg_int_ref;
    logic [1:0]         cfg_res;
    logic [1:0]         cfg_gain;
    logic [1:0]         cfg_refsel;
    logic [1:0]         cfg_mux;
    logic               cfg_exc_on;

    logic               timer_load;
    logic               timer_run;
    logic               timer_done;
    logic [TIMER_W-1:0] timer_value;
    logic [REG_W-1:0]   formatted_word;
    logic               capture;
    logic [REG_W-1:0]   status_word;
    logic [APB_DW-1:0]  read_mux;

    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------

    // address match against one register
    function automatic logic addr_is(input logic [APB_AW-1:0] a,
                                     input logic [APB_AW-1:0] target);
        return a == target;
    endfunction : addr_is

    // conversion length in clock cycles for the present mode
    function automatic logic [TIMER_W-1:0] conv_cycles(input logic       int_sense,
                                                       input logic       int_ref,
                                                       input logic [1:0] code);
        int unsigned ms;
        ms = INT_TIME_MS[code];
        if (!int_sense && int_ref) begin
            ms = EXT_TIME_MS_IREF[code];
        end else if (!int_sense) begin
            ms = EXT_TIME_MS_XREF[code];
        end
        return TIMER_W'(ms * CYCLES_PER_MS);
    endfunction : conv_cycles

    // byte-lane merge for the 16-bit configuration word
    function automatic logic [REG_W-1:0] lane_merge(input logic [REG_W-1:0]  old_v,
                                                    input logic [APB_DW-1:0] wdata,
                                                    input logic [3:0]        strb);
        logic [REG_W-1:0] v;
        v = old_v;
        if (strb[0]) begin
            v[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            v[15:8] = wdata[15:8];
        end
        return v;
    endfunction : lane_merge

    //------------------------------------------------------------------
    // apb decode
    //------------------------------------------------------------------

    // phases and register hits
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable;
    assign hit_result  = addr_is(paddr, ADDR_RESULT);
    assign hit_status  = addr_is(paddr, ADDR_STATUS);
    assign hit_config  = addr_is(paddr, ADDR_CONFIG);
    assign hit_any     = hit_result || hit_status || hit_config;

    // effects taken at the completing access edge
    assign cfg_write   = access_done && pwrite && hit_config;
    assign result_read = access_done && !pwrite && hit_result;

    // zero wait states: read data is staged in the setup cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    //------------------------------------------------------------------
    // configuration fields
    //------------------------------------------------------------------

    // field slices of the configuration register
    assign cfg_res       = config_reg[CFG_RES_HI:CFG_RES_LO];
    assign cfg_gain      = config_reg[CFG_GAIN_HI:CFG_GAIN_LO];
    assign cfg_mux       = config_reg[CFG_MUX_HI:CFG_MUX_LO];
    assign cfg_refsel    = config_reg[CFG_REFSEL_HI:CFG_REFSEL_LO];
    assign cfg_int_ref   = config_reg[CFG_INT_REF];
    assign cfg_int_sense = config_reg[CFG_INT_SENSE];
    assign cfg_conv_on   = config_reg[CFG_CONV_ON];
    assign cfg_exc_on    = config_reg[CFG_EXC_ON];

    // front-end controls straight from the stored configuration
    assign converter_on            = cfg_conv_on;
    assign internal_sensing_select = cfg_int_sense;
    assign resolution_select       = cfg_res;
    assign amp_gain_select         = cfg_gain;
    assign excitation_current_on   = cfg_exc_on;

    // input pair only matters when sensing outside the die
    assign input_mux_select = cfg_int_sense ? 2'b00 : cfg_mux;

    // gain factor is a power of two of the field code
    assign amp_gain_factor = GAIN_FACTOR_W'(1) << cfg_gain;

    // internal reference overrides the select pair
    always_comb begin
        converter_reference = REF_RESERVED;
        if (cfg_int_ref) begin
            converter_reference = REF_INTERNAL;
        end else begin
            case (cfg_refsel)
                2'b00:   converter_reference = REF_PIN;
                2'b01:   converter_reference = REF_EXC;
                2'b10:   converter_reference = REF_SUPPLY;
                default: converter_reference = REF_RESERVED;
            endcase
        end
    end

    //------------------------------------------------------------------
    // configuration register
    //------------------------------------------------------------------

    // factory bits are stored as written; they steer nothing here
    assign config_next = cfg_write ? lane_merge(config_reg, pwdata, pstrb) : config_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= CONFIG_RESET;
        end else begin
            config_reg <= config_next;
        end
    end

    //------------------------------------------------------------------
    // conversion sequencer
    //------------------------------------------------------------------

    // a configuration write restarts timing under the new mode
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CONV_OFF: begin
                if (cfg_conv_on && !cfg_write) begin
                    state_next = CONV_RUN;
                end
            end
            CONV_RUN: begin
                if (!cfg_conv_on || cfg_write) begin
                    state_next = CONV_OFF;
                end else if (timer_done) begin
                    state_next = CONV_DONE;
                end
            end
            CONV_DONE: begin
                if (!cfg_conv_on || cfg_write) begin
                    state_next = CONV_OFF;
                end else begin
                    state_next = CONV_RUN;               // continuous restart
                end
            end
            default: state_next = CONV_OFF;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= CONV_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // timer is reloaded when a conversion starts
    assign timer_load  = (state_next == CONV_RUN) && (state_reg != CONV_RUN);
    assign timer_run   = (state_reg == CONV_RUN);
    assign timer_value = conv_cycles(cfg_int_sense, cfg_int_ref, cfg_res);

    conv_timer #(
        .W          (TIMER_W)
    ) u_timer (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (timer_load),
        .load_value (timer_value),
        .run        (timer_run),
        .done       (timer_done),
        .remaining  ()
    );

    // status seen by the outside
    assign conversion_busy   = (state_reg == CONV_RUN);
    assign capture           = (state_reg == CONV_DONE);
    assign conversion_strobe = capture;

    //------------------------------------------------------------------
    // result path
    //------------------------------------------------------------------

    // resolution and sign extension of the raw sample
    result_formatter u_format (
        .raw_sample    (adc_raw_sample),
        .internal_mode (cfg_int_sense),
        .res_code      (cfg_res),
        .result_word   (formatted_word)
    );

    // whole word loaded in one edge, never piecewise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= RESULT_RESET;
        end else if (capture) begin
            result_reg <= formatted_word;
        end
    end

    // fresh flag: set at capture, cleared by reading the result; set wins
    assign fresh_next = capture ? 1'b1 : (result_read ? 1'b0 : fresh_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fresh_reg <= 1'b0;
        end else begin
            fresh_reg <= fresh_next;
        end
    end

    //------------------------------------------------------------------
    // read data and error staging
    //------------------------------------------------------------------

    // status word assembly
    always_comb begin
        status_word             = '0;
        status_word[STAT_BUSY]  = conversion_busy;
        status_word[STAT_FRESH] = fresh_reg;
    end

    // read multiplexer, unmapped reads return zero
    assign read_mux = hit_result ? APB_DW'(result_reg) :
                      hit_status ? APB_DW'(status_word) :
                      hit_config ? APB_DW'(config_reg) : '0;

    // error on unmapped address or write to a read-only word
    assign pslverr_next = setup_phase ? (!hit_any || (pwrite && !hit_config))
                                      : pslverr_reg;
    assign prdata_next  = setup_phase ? (pwrite ? '0 : read_mux) : prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

endmodule : temp_adc_ctrl

`default_nettype wire

// ===== dv/temp_adc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module temp_adc_ctrl_sva
    import temp_adc_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DFLT
) (
    // clock, reset and apb
    input wire logic [0:0]         pclk,
    input wire logic               presetn,
    input wire logic [APB_AW-1:0]  paddr,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [APB_DW-1:0]  pwdata,
    input wire logic [3:0]         pstrb,
    input wire logic [APB_DW-1:0]  prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // converter side
    input wire logic [REG_W-1:0]   adc_raw_sample,
    input wire logic               converter_on,
    input wire logic               internal_sensing_select,
    input wire logic [1:0]         resolution_select,
    input wire logic [1:0]         amp_gain_select,
    input wire logic [3:0]         amp_gain_factor,
    input wire ref_src_t           converter_reference,
    input wire logic [1:0]         input_mux_select,
    input wire logic               excitation_current_on,
    input wire logic               conversion_busy,
    input wire logic               conversion_strobe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // config write completing at this edge
    wire cfg_wr = psel && penable && pready && pwrite && paddr == ADDR_CONFIG;
    wire xref   = converter_reference != REF_INTERNAL;
    int unsigned run_cnt;
    // counts busy cycles of the conversion now running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) run_cnt <= 0;
        else run_cnt <= conversion_busy ? run_cnt + 1 : 0;
    end
    property p_res;
        cfg_wr && pstrb[0] |=> resolution_select == $past(pwdata[1:0]);
    endproperty
    a_res: assert property (p_res) else $error("resolution not taken");
    property p_tint;
        conversion_strobe && internal_sensing_select
            |-> run_cnt == CYCLES_PER_MS * INT_TIME_MS[resolution_select];
    endproperty
    a_tint: assert property (p_tint) else $error("internal time wrong");
    property p_mux;
        cfg_wr && pstrb == 4'hf && !pwdata[9] |=> input_mux_select == $past(pwdata[5:4]);
    endproperty
    a_mux: assert property (p_mux) else $error("input pair wrong");
    property p_gain;
        cfg_wr && pstrb[0] |=> amp_gain_factor == 4'(1 << $past(pwdata[3:2]));
    endproperty
    a_gain: assert property (p_gain) else $error("gain wrong");
    property p_exc;
        cfg_wr && pstrb[1] |=> excitation_current_on == $past(pwdata[11]);
    endproperty
    a_exc: assert property (p_exc) else $error("excitation wrong");
    property p_ref;
        cfg_wr && pstrb[1] && pwdata[8] |=> converter_reference == REF_INTERNAL;
    endproperty
    a_ref: assert property (p_ref) else $error("reference wrong");
    property p_txr;
        conversion_strobe && !internal_sensing_select && xref
            |-> run_cnt == CYCLES_PER_MS * EXT_TIME_MS_XREF[resolution_select];
    endproperty
    a_txr: assert property (p_txr) else $error("ext time wrong");
    property p_tir;
        conversion_strobe && !internal_sensing_select && !xref
            |-> run_cnt == CYCLES_PER_MS * EXT_TIME_MS_IREF[resolution_select];
    endproperty
    a_tir: assert property (p_tir) else $error("iref time wrong");
    property p_mode;
        cfg_wr && pstrb[1] |=> internal_sensing_select == $past(pwdata[9])
            && converter_on == $past(pwdata[10]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode bits wrong");
    property p_pulse;
        conversion_strobe |-> !conversion_busy ##1 !conversion_strobe;
    endproperty
    a_pulse: assert property (p_pulse) else $error("strobe not one cycle");
    c_int: cover property (conversion_strobe && internal_sensing_select);
    c_ir: cover property (conversion_strobe && !xref);
    c_err: cover property (psel && penable && pslverr);
endmodule : temp_adc_ctrl_sva
`default_nettype wire

// ===== dv/temp_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_model (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // converter enable and sensed temperature code
    input wire logic        converter_on,
    input wire logic [15:0] temp_code,
    output logic     [15:0] raw_sample
);
    // idle converter output wanders, never holds the last sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) raw_sample <= 16'h0000;
        else if (converter_on) raw_sample <= temp_code;
        else raw_sample <= ~raw_sample;
    end
endmodule : temp_sensor_model
`default_nettype wire

// ===== dv/temp_adc_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module temp_adc_ctrl_tb_top;
    import temp_adc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic conv_on, int_sel, exc_on, busy, strobe;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] lfsr = 32'd65689;
    logic [3:0]  pstrb, gain_fac;
    logic [15:0] temp_code, raw, cfg;
    logic [1:0]  res_sel, gain_sel, mux_sel, cc, rs;
    ref_src_t    ref_src;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;
    temp_adc_ctrl #(.CYCLES_PER_MS(4)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_raw_sample(raw),
        .converter_on(conv_on), .internal_sensing_select(int_sel),
        .resolution_select(res_sel), .amp_gain_select(gain_sel), .amp_gain_factor(gain_fac),
        .converter_reference(ref_src), .input_mux_select(mux_sel),
        .excitation_current_on(exc_on), .conversion_busy(busy), .conversion_strobe(strobe));
    temp_sensor_model sensor (.pclk(pclk), .presetn(presetn), .converter_on(conv_on),
        .temp_code(temp_code), .raw_sample(raw));
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // next state of the stimulus shift register
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // expected result word in the block's count units
    function automatic logic [15:0] fmt(logic [15:0] r, bit inner, int c);
        int v;
        v = $signed(r);
        if (inner) v = (v >>> 3) & ~((1 << (3 - c)) - 1);
        else v = v >>> (15 - EXT_RES_BITS[c]);
        return v[15:0];
    endfunction : fmt
    initial begin
        presetn = 0;
        {psel, penable, pwrite, paddr, pwdata, temp_code} = '0;
        pstrb = 4'hf;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ADDR_CONFIG, 0);
        check(rd, 0);
        apb(0, ADDR_RESULT, 0);
        check(rd, 0);
        apb(0, 8'h08, 0);
        check(err, 1);
        apb(1, ADDR_RESULT, 32'h1234);
        check(err, 1);
        // every mode and resolution code, result checked per conversion
        for (int m = 0; m < 3; m++) begin
            for (int c = 0; c < 4; c++) begin
                cc = 2'(c);
                rs = (c == 3) ? 2'b00 : cc;
                cfg = {4'h0, cc[0], 1'b1, m == 0, m == 2, rs, cc, cc, cc};
                temp_code <= (m == 0 && c == 3) ? 16'hf380 : lfsr[15:0];
                lfsr = lfsr_next(lfsr);
                apb(1, ADDR_CONFIG, {16'h0, cfg});
                check(ref_src, (m == 2) ? REF_INTERNAL : {1'b0, rs});
                check(gain_sel, cc);
                check(mux_sel, (m == 0) ? 2'b00 : cc);
                // strobe looked at mid-cycle, then the loading edge is let pass
                n = 0;
                do begin
                    @(negedge pclk);
                    n++;
                end while (strobe !== 1'b1 && n < 2000);
                check(strobe, 1);
                @(posedge pclk);
                apb(0, ADDR_STATUS, 0);
                check(rd, 32'h3);
                apb(0, ADDR_RESULT, 0);
                check(rd, {16'h0, fmt(temp_code, m == 0, c)});
            end
        end
        test_done();
    end
endmodule : temp_adc_ctrl_tb_top
bind temp_adc_ctrl temp_adc_ctrl_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) sva (.*);
`default_nettype wire
